// ### design/lics_charge_sequencer.sv
// Li-ion charge sequencer with status pin encoder and AHB-Lite registers.
// Operation
// - Cycle start with battery below trickle threshold selects trickle current.
// - Below trickle threshold over half an hour ends charging, bad battery.
// - Battery above trickle threshold moves to full constant-current charge.
// - Float voltage reached starts constant voltage and four-hour timer.
// - Safety timer expiry stops charging into the terminated state.
// - Qualified recharge indication in terminated state starts a new cycle.
// - Qualified recharge indication clears a running safety timer.
// - Recharge comparator counts only after more than 1.3 ms asserted.
// - Supply lockout or enable cycling restarts charge and clears timer.
// - Status pin held low throughout a normal charge cycle.
// - Float voltage with tenth-current flag releases the status pin.
// - Faults switch the status pin at 35 kHz with blinking duty.
// - Thermistor fault alternates 6.25% and 93.75% duty at 1.5 Hz.
// - Bad battery alternates 12.5% and 87.5% duty at 6.1 Hz.
// - Tenth-current flag ignored while input current limit is active.
// - Thermistor hot comparator pauses charging until it clears.
// - Thermistor cold comparator pauses charging until it clears.
// - Thermistor pause in constant voltage also freezes the safety timer.
// - Grounded thermistor input disables thermistor pausing.
`timescale 1ns/1ps
`include "lics_cfg.svh"
module lics_charge_sequencer import lics_pkg::*; #(
  parameter int unsigned TICK_CYC = `LICS_TICK_CYC,
  parameter int unsigned FILT_CYC = `LICS_FILT_CYC,
  parameter int unsigned SLICE_CYC = `LICS_SLICE_CYC,
  parameter int unsigned TRKL_LIMIT_MS = `LICS_TRKL_LIMIT_MS,
  parameter int unsigned SAFETY_MS = `LICS_SAFETY_MS,
  parameter int unsigned NTC_HALF_MS = `LICS_NTC_HALF_MS,
  parameter int unsigned BAD_HALF_MS = `LICS_BAD_HALF_MS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic bat_below_trickle,
  input wire logic float_reached,
  input wire logic tenth_current,
  input wire logic input_ilim_active,
  input wire logic below_recharge,
  input wire logic supply_ok,
  input wire logic therm_hot,
  input wire logic therm_cold,
  input wire logic thermistor_grounded,
  input wire logic charger_enable_n,
  output logic charge_status_out,
  output logic charge_status_oe,
  output logic charge_on,
  output logic trickle_mode,
  output logic cv_mode
);

  // ==========================================================
  // Input synchronisers
  logic [9:0] raw_in;
  logic [9:0] sync1_q;
  logic [9:0] sync2_q;
  logic bat_low_s, float_s, tenth_s, ilim_s, below_s;
  logic uvlo_s, hot_s, cold_s, gnd_s, en_n_s;

  assign raw_in = {charger_enable_n, thermistor_grounded, therm_cold,
                   therm_hot, supply_ok, below_recharge, input_ilim_active,
                   tenth_current, float_reached, bat_below_trickle};
  assign {en_n_s, gnd_s, cold_s, hot_s, uvlo_s, below_s, ilim_s,
          tenth_s, float_s, bat_low_s} = sync2_q;

  // Two stages; only the second stage feeds any logic.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 10'h000;
      sync2_q <= 10'h000;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // Register bus
  logic ctrl_en_q;
  logic wr_pend_q;
  logic [7:0] wr_ofs_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_mux;
  logic acc;
  lics_state_t state_q;
  logic [31:0] tmr_q;
  logic eoc_q;
  logic phase_q;
  logic oe_q;
  logic qual_q;
  logic pause;
  assign acc = hsel & htrans[1] & hready & (hsize == 3'h2);
  // Read data is muxed at the address phase so it sits in a flop.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (haddr[7:0])
      `LICS_CTRL_OFS: rd_mux[`LICS_CTRL_EN_BIT] = ctrl_en_q;
      `LICS_STAT_OFS: rd_mux[7:0] = {qual_q, oe_q, phase_q, pause, eoc_q,
                                     state_q};
      `LICS_TMR_OFS: rd_mux = tmr_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Zero wait states; every transfer answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_ofs_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= acc & hwrite;
      if (acc) begin
        wr_ofs_q <= haddr[7:0];
      end
      if (acc && !hwrite) begin
        hrdata_q <= rd_mux;
      end
    end
  end

  // Software enable; toggling it restarts the cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_q <= `LICS_CTRL_RST;
    end else if (wr_pend_q && wr_ofs_q == `LICS_CTRL_OFS) begin
      ctrl_en_q <= hwdata[`LICS_CTRL_EN_BIT];
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================
  // Dividers: millisecond tick and pulse slice enable
  logic [31:0] tick_cnt_q;
  logic [31:0] slice_cnt_q;
  logic tick;
  logic slice_en;
  logic [3:0] slice_q;

  assign tick = (tick_cnt_q == TICK_CYC - 1);
  assign slice_en = (slice_cnt_q == SLICE_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 32'h0;
      slice_cnt_q <= 32'h0;
      slice_q <= 4'h0;
    end else begin
      tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
      slice_cnt_q <= slice_en ? 32'h0 : slice_cnt_q + 32'h1;
      if (slice_en) begin
        slice_q <= slice_q + 4'h1;
      end
    end
  end

  // ==========================================================
  // Recharge comparator filter
  logic [31:0] filt_q;
  logic qual_d1_q;
  logic rech_ev;

  // A single dip longer than the filter makes one event, not a stream.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_q <= 32'h0;
      qual_q <= 1'b0;
      qual_d1_q <= 1'b0;
    end else begin
      qual_d1_q <= qual_q;
      if (!below_s) begin
        filt_q <= 32'h0;
        qual_q <= 1'b0;
      end else if (filt_q == FILT_CYC - 1) begin
        qual_q <= 1'b1;
      end else begin
        filt_q <= filt_q + 32'h1;
      end
    end
  end

  assign rech_ev = qual_q & ~qual_d1_q;

  // ==========================================================
  // Enable qualification and restart detection
  logic en_now;
  logic en_prev_q;
  logic restart;
  assign en_now = ctrl_en_q & ~en_n_s & uvlo_s;
  assign restart = en_now & ~en_prev_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= en_now;
    end
  end

  // ==========================================================
  // Sequencer
  logic charging;
  logic tmr_lim;
  logic [31:0] lim;
  assign pause = (hot_s | cold_s) & ~gnd_s;
  assign charging = (state_q == LICS_TRICKLE) || (state_q == LICS_CC) ||
                    (state_q == LICS_CV);
  assign lim = (state_q == LICS_TRICKLE) ? TRKL_LIMIT_MS : SAFETY_MS;
  assign tmr_lim = tick && (tmr_q == lim - 1);

  // Lockout or a disabled charger forces idle regardless of state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= LICS_IDLE;
    end else if (!en_now) begin
      state_q <= LICS_IDLE;
    end else if (restart) begin
      state_q <= bat_low_s ? LICS_TRICKLE : LICS_CC;
    end else begin
      unique case (state_q)
        LICS_IDLE: state_q <= LICS_IDLE;
        LICS_TRICKLE: begin
          if (!bat_low_s) begin
            state_q <= LICS_CC;
          end else if (tmr_lim) begin
            state_q <= LICS_BADBAT;
          end
        end
        LICS_CC: begin
          if (float_s) begin
            state_q <= LICS_CV;
          end
        end
        LICS_CV: begin
          if (tmr_lim && !rech_ev && !pause) begin
            state_q <= LICS_DONE;
          end
        end
        LICS_DONE: begin
          if (rech_ev) begin
            state_q <= bat_low_s ? LICS_TRICKLE : LICS_CC;
          end
        end
        LICS_BADBAT: state_q <= LICS_BADBAT;
      endcase
    end
  end

  // Timer in ms ticks; trickle uses it for the bad-cell timeout.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tmr_q <= 32'h0;
    end else if (restart || !en_now) begin
      tmr_q <= 32'h0;
    end else if (state_q == LICS_CC && float_s) begin
      tmr_q <= 32'h0;
    end else if (rech_ev && (state_q == LICS_CV || state_q == LICS_DONE)) begin
      tmr_q <= 32'h0;
    end else if (state_q == LICS_CV && pause) begin
      tmr_q <= tmr_q;
    end else if ((state_q == LICS_TRICKLE || state_q == LICS_CV) && tick) begin
      tmr_q <= tmr_lim ? 32'h0 : tmr_q + 32'h1;
    end
  end

  // End of charge latches in float; current limit masks the flag.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eoc_q <= 1'b0;
    end else if (state_q != LICS_CV || restart) begin
      eoc_q <= 1'b0;
    end else if (tenth_s && !ilim_s) begin
      eoc_q <= 1'b1;
    end
  end

  // Current commands to the analog charger.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      charge_on <= 1'b0;
      trickle_mode <= 1'b0;
      cv_mode <= 1'b0;
    end else begin
      charge_on <= charging & ~pause & en_now;
      trickle_mode <= (state_q == LICS_TRICKLE);
      cv_mode <= (state_q == LICS_CV);
    end
  end

  // ==========================================================
  // Status pin encoder
  logic [31:0] blink_q;
  logic [31:0] half;
  logic bad;
  logic thermistor_sense;
  logic [3:0] duty;
  assign bad = (state_q == LICS_BADBAT);
  assign thermistor_sense = charging & pause;
  assign half = bad ? BAD_HALF_MS : NTC_HALF_MS;

  // Low slices out of sixteen for a fault and blink phase.
  function automatic logic [3:0] duty_of(input logic b, input logic ph);
    if (b) begin
      duty_of = ph ? `LICS_BAD_DUTY_HI : `LICS_BAD_DUTY_LO;
    end else begin
      duty_of = ph ? `LICS_NTC_DUTY_HI : `LICS_NTC_DUTY_LO;
    end
  endfunction
  assign duty = duty_of(bad, phase_q);

  // Blink phase flips every half period; held at zero with no fault.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_q <= 32'h0;
      phase_q <= 1'b0;
    end else if (!bad && !thermistor_sense) begin
      blink_q <= 32'h0;
      phase_q <= 1'b0;
    end else if (tick) begin
      if (blink_q >= half - 1) begin
        blink_q <= 32'h0;
        phase_q <= ~phase_q;
      end else begin
        blink_q <= blink_q + 32'h1;
      end
    end
  end

  // Enable high pulls the open-drain pin low.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oe_q <= 1'b0;
    end else if (bad || thermistor_sense) begin
      oe_q <= (slice_q < duty);
    end else begin
      oe_q <= charging & ~eoc_q;
    end
  end

  assign charge_status_oe = oe_q;
  assign charge_status_out = 1'b0;

  // ==========================================================
  // Checks
  AST_TRKL_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
    restart && bat_low_s |=> state_q == LICS_TRICKLE && trickle_mode == 1'b0
    ##1 trickle_mode) else $error("trickle not selected at cycle start");
  AST_BADBAT: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == LICS_TRICKLE && en_now && !restart && bat_low_s && tmr_lim
    |=> state_q == LICS_BADBAT) else $error("bad cell timeout missed");
  AST_TO_CC: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == LICS_TRICKLE && en_now && !restart && !bat_low_s
    |=> state_q == LICS_CC) else $error("trickle did not end");
  AST_TO_CV: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == LICS_CC && en_now && !restart && float_s
    |=> state_q == LICS_CV && tmr_q == 32'h0) else $error("cv entry wrong");
  AST_DONE_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == LICS_DONE |=> !charge_on) else $error("current after end");
  AST_RECHG: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == LICS_DONE && en_now && !restart && rech_ev
    |=> charging) else $error("recharge did not start");
  AST_TMR_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
    (restart || (rech_ev && state_q == LICS_CV)) |=> tmr_q == 32'h0)
    else $error("timer not cleared");
  AST_FILT: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(qual_q) |-> $past(below_s) && filt_q == FILT_CYC - 1)
    else $error("recharge qualified early");
  AST_FREEZE: assert property (@(posedge hclk) disable iff (!hresetn)
    state_q == LICS_CV && pause && en_now && !restart && !rech_ev
    |=> $stable(tmr_q)) else $error("timer ran while paused");
  AST_LOW: assert property (@(posedge hclk) disable iff (!hresetn)
    charging && !pause && !eoc_q |=> oe_q) else $error("pin not low");
  AST_DUTY: assert property (@(posedge hclk) disable iff (!hresetn)
    bad |=> oe_q == ($past(slice_q) < $past(duty)))
    else $error("fault duty wrong");
  AST_GND: assert property (@(posedge hclk) disable iff (!hresetn)
    gnd_s && charging && en_now |=> charge_on)
    else $error("grounded thermistor paused");

endmodule // lics_charge_sequencer

// ### design/lics_cfg.svh
// Offsets, field positions, reset values and timing counts of the sequencer.
`ifndef LICS_CFG_SVH
`define LICS_CFG_SVH
// ==========================================================
// Clock and time figures
`define LICS_CLK_HZ 200000000
`define LICS_TICK_MS 1
`define LICS_TICK_CYC (`LICS_CLK_HZ / 1000 * `LICS_TICK_MS)
`define LICS_TRKL_LIMIT_S 1800
`define LICS_TRKL_LIMIT_MS (`LICS_TRKL_LIMIT_S * 1000)
`define LICS_SAFETY_H 4
`define LICS_SAFETY_MS (`LICS_SAFETY_H * 3600 * 1000)
`define LICS_FILT_US 1300
`define LICS_FILT_CYC (`LICS_FILT_US * (`LICS_CLK_HZ / 1000000) + 1)
`define LICS_PULSE_HZ 35000
`define LICS_SLICE_CYC (`LICS_CLK_HZ / `LICS_PULSE_HZ / 16)
`define LICS_BLINK_NTC_MHZ 1500
`define LICS_BLINK_BAD_MHZ 6100
`define LICS_NTC_HALF_MS (1000000 / (2 * `LICS_BLINK_NTC_MHZ))
`define LICS_BAD_HALF_MS (1000000 / (2 * `LICS_BLINK_BAD_MHZ))
// ==========================================================
// Duty cycles as low slices out of sixteen
`define LICS_NTC_DUTY_LO 4'h1
`define LICS_NTC_DUTY_HI 4'hf
`define LICS_BAD_DUTY_LO 4'h2
`define LICS_BAD_DUTY_HI 4'he
// ==========================================================
// Register map
`define LICS_CTRL_OFS 8'h00
`define LICS_STAT_OFS 8'h04
`define LICS_TMR_OFS 8'h08
`define LICS_CTRL_EN_BIT 0
`define LICS_CTRL_RST 1'b1
`endif

// ### design/lics_pkg.sv
// Types shared by the charge sequencer.
package lics_pkg;
  typedef enum logic [2:0] {
    LICS_IDLE,
    LICS_TRICKLE,
    LICS_CC,
    LICS_CV,
    LICS_DONE,
    LICS_BADBAT
  } lics_state_t;
endpackage

// ### sim/lics_status_monitor.sv
// Model of the processor that reads the status pin and measures its duty.
`timescale 1ns/1ps
module lics_status_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic oe,
  input wire logic dout,
  output logic pin,
  output logic meas_valid,
  output logic [15:0] period,
  output logic [15:0] low_cnt
);
  logic prev_q;
  logic started_q;
  logic [15:0] cnt_q;
  logic [15:0] low_q;
  // ==========================================================
  // Pin level
  // A released open-drain pin is pulled up, never left at the last value.
  assign pin = oe ? dout : 1'b1;
  // ==========================================================
  // Duty measurement
  // Each carrier period runs from one falling pin edge to the next.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b1;
      started_q <= 1'b0;
      cnt_q <= 16'h0000;
      low_q <= 16'h0000;
      meas_valid <= 1'b0;
      period <= 16'h0000;
      low_cnt <= 16'h0000;
    end else begin
      prev_q <= pin;
      meas_valid <= 1'b0;
      if (prev_q && !pin) begin
        // A reading of exactly half straddles a blink flip and is dropped.
        if (started_q && (low_q * 2 != cnt_q)) begin
          meas_valid <= 1'b1;
          period <= cnt_q;
          low_cnt <= low_q;
        end
        started_q <= 1'b1;
        cnt_q <= 16'h0001;
        low_q <= 16'h0001;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
        low_q <= low_q + {15'h0000, ~pin};
      end
    end
  end
endmodule // lics_status_monitor

// ### sim/test_li_ion_charge_sequencer.sv
// Self-checking testbench for the charge sequencer.
`timescale 1ns/1ps
module test_li_ion_charge_sequencer import lics_pkg::*;;
  localparam int TK = 64;
  localparam int SL = 2;
  localparam int PER = 16 * SL;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, obs_v;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, chk_req = 1'b0, kind_q = 1'b0, mv;
  logic bat_below_trickle = 1'b0, float_reached = 1'b0;
  logic tenth_current = 1'b0, input_ilim_active = 1'b0;
  logic below_recharge = 1'b0, supply_ok = 1'b0;
  logic therm_hot = 1'b0, therm_cold = 1'b0, thermistor_grounded = 1'b0;
  logic charger_enable_n = 1'b0, charge_status_out, charge_status_oe;
  logic charge_on, trickle_mode, cv_mode;
  logic [15:0] mper, mlow;
  logic [31:0] v, notes[$];
  int error_cnt = 0, samples_checked = 0, seed = 67;
  // ==========================================================
  // Clock, design and status reader
  always #2.5 hclk = ~hclk;
  lics_charge_sequencer #(.TICK_CYC(TK), .FILT_CYC(20), .SLICE_CYC(SL),
    .TRKL_LIMIT_MS(5), .SAFETY_MS(8), .NTC_HALF_MS(3), .BAD_HALF_MS(2))
  u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .bat_below_trickle(bat_below_trickle),
    .float_reached(float_reached), .tenth_current(tenth_current),
    .input_ilim_active(input_ilim_active), .below_recharge(below_recharge),
    .supply_ok(supply_ok), .therm_hot(therm_hot), .therm_cold(therm_cold),
    .thermistor_grounded(thermistor_grounded),
    .charger_enable_n(charger_enable_n),
    .charge_status_out(charge_status_out),
    .charge_status_oe(charge_status_oe), .charge_on(charge_on),
    .trickle_mode(trickle_mode), .cv_mode(cv_mode));
  lics_status_monitor u_mon (.clk(hclk), .rstn(hresetn),
    .oe(charge_status_oe), .dout(charge_status_out), .pin(),
    .meas_valid(mv), .period(mper), .low_cnt(mlow));
  // ==========================================================
  // Scoreboard: the oldest note is compared when a check is raised.
  always @(negedge hclk) begin
    logic [31:0] e, g;
    if (chk_req) begin
      e = notes.pop_front();
      g = kind_q ? {28'h0, charge_status_oe, charge_on, trickle_mode,
        cv_mode} : obs_v;
      samples_checked++;
      if (g !== e) begin
        error_cnt++;
        $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
    end
  end
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tmo();
    error_cnt++;
    give_verdict();
  endtask
  // Kind 1 compares the status outputs, kind 0 the value handed in.
  task automatic check(input logic [31:0] e, input bit k,
      input logic [31:0] g);
    notes.push_back(e);
    obs_v <= g;
    kind_q <= k;
    chk_req <= 1'b1;
    @(posedge hclk);
    chk_req <= 1'b0;
    @(posedge hclk);
  endtask
  // One word transfer; each phase is held until hready is seen high.
  task automatic ahb(input bit w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    n = 0;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) tmo();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
    rd = hrdata;
    if (n >= 99) tmo();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    do begin ahb(1'b0, 8'h04, 32'h0, v); n++; end
    while (v[2:0] !== s && n < 1500);
    if (n >= 1500) tmo();
  endtask
  task automatic go(input logic [2:0] s, input logic [3:0] e);
    wait_st(s);
    repeat (2) @(posedge hclk);
    check({28'h0, e}, 1'b1, 32'h0);
  endtask
  // Counts carrier periods of the low and high duty and the longest run.
  task automatic blink(input int lo, input int hi, input int run);
    int nlo, nhi, cur, mx;
    nlo = 0;
    nhi = 0;
    cur = 0;
    mx = 0;
    repeat (1200) begin
      @(posedge hclk);
      if (mv === 1'b1 && mper == PER) begin
        if (mlow == lo * SL) begin nlo++; cur++; if (cur > mx) mx = cur; end
        else begin cur = 0; if (mlow == hi * SL) nhi++; end
      end
    end
    check(32'h1, 1'b0, {31'h0, nlo > 0 && nhi > 0 && mx >= run - 1
      && mx <= run});
  endtask
  task automatic dip(input int n);
    below_recharge <= 1'b1;
    repeat (n) @(posedge hclk);
    below_recharge <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    int n;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check(32'h0, 1'b1, 32'h0);
    ahb(1'b0, 8'h00, 32'h0, v);
    check(32'h1, 1'b0, v);
    ahb(1'b0, 8'h08, 32'h0, v);
    check(32'h0, 1'b0, v);
    wr(8'h0c, $random(seed));
    ahb(1'b0, 8'h0c, 32'h0, v);
    check(32'h0, 1'b0, v);
    wr(8'h04, $random(seed));
    ahb(1'b0, 8'h04, 32'h0, v);
    check(32'h0, 1'b0, {29'h0, v[2:0]});
    bat_below_trickle <= 1'b1;
    supply_ok <= 1'b1;
    go(LICS_TRICKLE, 4'he);
    // The pin toggles in a fault, so only the current commands are compared.
    wait_st(LICS_BADBAT);
    repeat (2) @(posedge hclk);
    check(32'h0, 1'b0, {29'h0, charge_on, trickle_mode, cv_mode});
    blink(2, 14, 2 * TK / PER);
    wr(8'h00, 32'h0);
    go(LICS_IDLE, 4'h0);
    wr(8'h00, 32'h1);
    go(LICS_TRICKLE, 4'he);
    bat_below_trickle <= 1'b0;
    go(LICS_CC, 4'hc);
    float_reached <= 1'b1;
    go(LICS_CV, 4'hd);
    input_ilim_active <= 1'b1;
    tenth_current <= 1'b1;
    repeat (8) @(posedge hclk);
    check(32'hd, 1'b1, 32'h0);
    input_ilim_active <= 1'b0;
    repeat (8) @(posedge hclk);
    check(32'h5, 1'b1, 32'h0);
    tenth_current <= 1'b0;
    n = 0;
    do begin ahb(1'b0, 8'h08, 32'h0, v); n++; end
    while (v < 4 && n < 400);
    if (n >= 400) tmo();
    dip(10);
    ahb(1'b0, 8'h08, 32'h0, v);
    check(32'h1, 1'b0, {31'h0, v >= 4});
    dip(40);
    ahb(1'b0, 8'h08, 32'h0, v);
    check(32'h1, 1'b0, {31'h0, v <= 1});
    go(LICS_DONE, 4'h0);
    float_reached <= 1'b0;
    dip(40);
    go(LICS_CC, 4'hc);
    float_reached <= 1'b1;
    go(LICS_CV, 4'hd);
    below_recharge <= 1'b1;
    repeat (40) @(posedge hclk);
    below_recharge <= 1'b0;
    therm_hot <= 1'b1;
    repeat (8) @(posedge hclk);
    check(32'h0, 1'b0, {31'h0, charge_on});
    blink(1, 15, 3 * TK / PER);
    ahb(1'b0, 8'h08, 32'h0, v);
    check(32'h1, 1'b0, {31'h0, v <= 1});
    therm_hot <= 1'b0;
    repeat (8) @(posedge hclk);
    check(32'hd, 1'b1, 32'h0);
    therm_cold <= 1'b1;
    repeat (8) @(posedge hclk);
    check(32'h0, 1'b0, {31'h0, charge_on});
    thermistor_grounded <= 1'b1;
    repeat (8) @(posedge hclk);
    check(32'h1, 1'b0, {31'h0, charge_on});
    therm_cold <= 1'b0;
    supply_ok <= 1'b0;
    go(LICS_IDLE, 4'h0);
    bat_below_trickle <= 1'b1;
    supply_ok <= 1'b1;
    go(LICS_TRICKLE, 4'he);
    charger_enable_n <= 1'b1;
    go(LICS_IDLE, 4'h0);
    charger_enable_n <= 1'b0;
    go(LICS_TRICKLE, 4'he);
    give_verdict();
  end
endmodule // test_li_ion_charge_sequencer
